/* hw/prc_pkg.sv */
// Constants and types shared by the peripheral reset, sleep and clock control block.
// Function
// - Software request pulses the reset lines of the units it selects
// - Reset unit stays enabled and clocked
// - Sleep stops clock of non-sleep-run units
// - Leaving sleep restarts gated clocks, state kept
// - Sleep-run settings act only with gating on
// - Sleep-run units keep clock and wake processor
// - Enabled PLL watch raises interrupt on stop
// - PLL watch uses running main oscillator
// - PWM clock divided 1 to 64, readable
// - Soft reset resets processor, units, registers
// - Soft reset keeps cause bits, sets software bit
// - Unit usable five cycles after enable
// - Disabled units idle; all start disabled
package prc_pkg;

   // ****************************************************************
   // Sizes and register offsets
   // ****************************************************************
   localparam int N_UNITS = 8;
   localparam int ADR_W = 8;
   localparam logic [7:0] OFF_UNIT_EN = 8'h00;
   localparam logic [7:0] OFF_SLEEP_RUN = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_UNIT_RST = 8'h0C;
   localparam logic [7:0] OFF_SOFT_RST = 8'h10;
   localparam logic [7:0] OFF_CAUSE = 8'h14;
   localparam logic [7:0] OFF_INT_STAT = 8'h18;
   localparam logic [7:0] OFF_INT_MASK = 8'h1C;
   localparam logic [7:0] OFF_UNIT_READY = 8'h20;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int SOFT_RST_GO_BIT = 0;
   localparam int CAUSE_EXT_BIT = 0;
   localparam int CAUSE_SW_BIT = 4;
   localparam logic [5:0] CAUSE_RST = 6'h01;
   localparam int INT_PLL_LOST_BIT = 0;
   localparam int INT_RST_DONE_BIT = 1;
   localparam logic [1:0] INT_RST = 2'h0;
   localparam logic [7:0] UNIT_RST_VAL = 8'h00;
   localparam logic [2:0] PWM_DIV_MAX = 3'h6;

   // ****************************************************************
   // Cycle counts
   // ****************************************************************
   localparam logic [2:0] RST_PULSE_CYC = 3'h4;
   localparam logic [2:0] ENABLE_DELAY_CYC = 3'h5;
   localparam logic [3:0] SOFT_RST_CYC = 4'h8;
   localparam logic [4:0] PLL_WATCH_OSC_TICKS = 5'h10;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic [2:0] pwm_div;
      logic watch_en;
      logic gate_en;
   } prc_ctrl_t;

   localparam prc_ctrl_t CTRL_RST = '{pwm_div: 3'h0, watch_en: 1'b0, gate_en: 1'b0};

   typedef struct packed {
      logic rst_done;
      logic pll_lost;
   } prc_int_t;

endpackage

/* hw/prc_pwm_div.sv */
// PWM clock enable divider, dividing the system clock by a power of two.
`timescale 1ns/1ps
`default_nettype none
module prc_pwm_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] div_code_i,
   output logic tick_o
);

   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;
   logic [5:0] mask;

   // A tick is raised when the low code bits of the count are all ones.
   always_comb begin
      mask = 6'(({6'h0, 1'b1} << div_code_i) - 7'h01);
      cnt_nxt = cnt_r + 6'h01;
      tick_nxt = ((cnt_r & mask) == mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 6'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   pwm_full_rate_a: assert property ((div_code_i == 3'h0) ##1 (div_code_i == 3'h0) |-> tick_o)
      else $error("PWM tick missing at ratio one");
   pwm_half_rate_a: assert property ((div_code_i == 3'h1)[*3] |-> (tick_o != $past(tick_o)))
      else $error("PWM tick not alternating at ratio two");

endmodule
`default_nettype wire

/* hw/prc_ctrl.sv */
// Peripheral reset, sleep clock gating, PLL watch and soft reset controller.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module prc_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sleep_i,
   input wire logic [7:0] unit_wake_i,
   input wire logic osc_run_i,
   input wire logic osc_tick_i,
   input wire logic pll_tick_i,
   output logic [7:0] unit_clk_en_o,
   output logic [7:0] unit_rst_o,
   output logic [7:0] unit_ready_o,
   output logic pwm_clk_en_o,
   output logic wake_o,
   output logic chip_reset_o,
   output logic irq_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [7:0] en_r, en_nxt;
   logic [7:0] srun_r, srun_nxt;
   prc_pkg::prc_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] rmask_r, rmask_nxt;
   logic [2:0] rcnt_r, rcnt_nxt;
   logic [7:0] urst_r, urst_nxt;
   logic [7:0] clken_r, clken_nxt;
   logic [7:0] ready_r, ready_nxt;
   logic [7:0][2:0] dcnt_r, dcnt_nxt;
   logic wake_r, wake_nxt;
   logic [4:0] wcnt_r, wcnt_nxt;
   prc_pkg::prc_int_t ist_r, ist_nxt;
   prc_pkg::prc_int_t imask_r, imask_nxt;
   logic irq_r, irq_nxt;
   logic [3:0] scnt_r, scnt_nxt;
   logic chip_r, chip_nxt;
   logic [5:0] cause_r, cause_nxt;
   logic srst;
   logic wr;
   logic soft_go;
   logic lost_evt;
   logic done_evt;
   logic [31:0] wmask;
   logic [31:0] wdat;

   // Registers return to defaults on the power reset, and all but the cause record at the end of a soft reset.
   assign srst = rst_i || (scnt_r == 4'h1);
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdat = wb_dat_i & wmask;
   assign soft_go = wr && (wb_adr_i == prc_pkg::OFF_SOFT_RST) && wdat[prc_pkg::SOFT_RST_GO_BIT] && (scnt_r == 4'h0);

   // ****************************************************************
   // Wishbone slave and software registers
   // ****************************************************************
   always_comb begin
      ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
      dat_nxt = 32'h0000_0000;
      en_nxt = en_r;
      srun_nxt = srun_r;
      ctrl_nxt = ctrl_r;
      imask_nxt = imask_r;
      if (wr) begin
         case (wb_adr_i)
            prc_pkg::OFF_UNIT_EN: begin
               en_nxt = (en_r & ~wmask[7:0]) | wdat[7:0];
            end
            prc_pkg::OFF_SLEEP_RUN: begin
               srun_nxt = (srun_r & ~wmask[7:0]) | wdat[7:0];
            end
            prc_pkg::OFF_CTRL: begin
               if (wb_sel_i[0]) begin
                  ctrl_nxt = prc_pkg::prc_ctrl_t'(wb_dat_i[4:0]);
                  if (wb_dat_i[4:2] > prc_pkg::PWM_DIV_MAX) begin
                     ctrl_nxt.pwm_div = prc_pkg::PWM_DIV_MAX;
                  end
               end
            end
            prc_pkg::OFF_INT_MASK: begin
               imask_nxt = (imask_r & ~wmask[1:0]) | wdat[1:0];
            end
            default: begin
            end
         endcase
      end
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
         case (wb_adr_i)
            prc_pkg::OFF_UNIT_EN: dat_nxt = {24'h0, en_r};
            prc_pkg::OFF_SLEEP_RUN: dat_nxt = {24'h0, srun_r};
            prc_pkg::OFF_CTRL: dat_nxt = {27'h0, ctrl_r};
            prc_pkg::OFF_UNIT_RST: dat_nxt = {24'h0, urst_r};
            prc_pkg::OFF_SOFT_RST: dat_nxt = {31'h0, chip_r};
            prc_pkg::OFF_CAUSE: dat_nxt = {26'h0, cause_r};
            prc_pkg::OFF_INT_STAT: dat_nxt = {30'h0, ist_r};
            prc_pkg::OFF_INT_MASK: dat_nxt = {30'h0, imask_r};
            prc_pkg::OFF_UNIT_READY: dat_nxt = {24'h0, ready_r};
            default: dat_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         en_r <= 8'h00;
         srun_r <= 8'h00;
         ctrl_r <= prc_pkg::CTRL_RST;
         imask_r <= prc_pkg::INT_RST;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         en_r <= en_nxt;
         srun_r <= srun_nxt;
         ctrl_r <= ctrl_nxt;
         imask_r <= imask_nxt;
      end
   end

   // ****************************************************************
   // Unit reset pulse, clock gating and enable delay
   // ****************************************************************
   assign done_evt = (rcnt_r == 3'h1);

   always_comb begin
      rmask_nxt = rmask_r;
      rcnt_nxt = (rcnt_r != 3'h0) ? rcnt_r - 3'h1 : 3'h0;
      // A new request is taken only between pulses, so other units stay untouched.
      if (wr && (wb_adr_i == prc_pkg::OFF_UNIT_RST) && (rcnt_r == 3'h0) && (wdat[7:0] != 8'h00)) begin
         rmask_nxt = wdat[7:0];
         rcnt_nxt = prc_pkg::RST_PULSE_CYC;
      end
      urst_nxt = (rcnt_nxt != 3'h0) ? rmask_nxt : prc_pkg::UNIT_RST_VAL;
      // The clock stays on through a reset pulse so the synchronous reset lands.
      clken_nxt = urst_nxt;
      if (!sleep_i || !ctrl_r.gate_en) begin
         clken_nxt = clken_nxt | en_r;
      end else begin
         clken_nxt = clken_nxt | (en_r & srun_r);
      end
      wake_nxt = sleep_i && ((unit_wake_i & clken_r & en_r) != 8'h00);
   end

   for (genvar g = 0; g < prc_pkg::N_UNITS; g++) begin : g_unit
      always_comb begin
         dcnt_nxt[g] = 3'h0;
         if (en_r[g]) begin
            dcnt_nxt[g] = (dcnt_r[g] == prc_pkg::ENABLE_DELAY_CYC) ? dcnt_r[g] : dcnt_r[g] + 3'h1;
         end
         // A disabling write drops ready at once, so a disabled unit is never reported usable.
         ready_nxt[g] = en_r[g] && en_nxt[g] && (dcnt_nxt[g] == prc_pkg::ENABLE_DELAY_CYC);
      end
   end

   // The gate enables are registered, so an external latch gate never sees a glitch.
   always_ff @(posedge clk_i) begin
      if (srst) begin
         rmask_r <= 8'h00;
         rcnt_r <= 3'h0;
         urst_r <= prc_pkg::UNIT_RST_VAL;
         clken_r <= 8'h00;
         ready_r <= 8'h00;
         dcnt_r <= '0;
         wake_r <= 1'b0;
      end else begin
         rmask_r <= rmask_nxt;
         rcnt_r <= rcnt_nxt;
         urst_r <= urst_nxt;
         clken_r <= clken_nxt;
         ready_r <= ready_nxt;
         dcnt_r <= dcnt_nxt;
         wake_r <= wake_nxt;
      end
   end

   // ****************************************************************
   // PLL watch timer and interrupts
   // ****************************************************************
   // Count clears to zero while the oscillator is stopped; software turns it off around PLL changes.
   assign lost_evt = ctrl_r.watch_en && osc_run_i && osc_tick_i && !pll_tick_i
                     && (wcnt_r == prc_pkg::PLL_WATCH_OSC_TICKS - 5'h01);

   always_comb begin
      wcnt_nxt = wcnt_r;
      if (!ctrl_r.watch_en || !osc_run_i || pll_tick_i) begin
         wcnt_nxt = 5'h00;
      end else if (osc_tick_i && (wcnt_r != prc_pkg::PLL_WATCH_OSC_TICKS)) begin
         wcnt_nxt = wcnt_r + 5'h01;
      end
      ist_nxt = ist_r;
      if (wr && (wb_adr_i == prc_pkg::OFF_INT_STAT)) begin
         ist_nxt = ist_r & ~prc_pkg::prc_int_t'(wdat[1:0]);
      end
      // Hardware set wins over a write-one clear in the same cycle.
      ist_nxt.pll_lost = ist_nxt.pll_lost | lost_evt;
      ist_nxt.rst_done = ist_nxt.rst_done | done_evt;
      irq_nxt = ((ist_nxt & imask_nxt) != 2'h0);
   end

   always_ff @(posedge clk_i) begin
      if (srst) begin
         wcnt_r <= 5'h00;
         ist_r <= prc_pkg::INT_RST;
         irq_r <= 1'b0;
      end else begin
         wcnt_r <= wcnt_nxt;
         ist_r <= ist_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ****************************************************************
   // Whole-device soft reset and reset cause
   // ****************************************************************
   always_comb begin
      scnt_nxt = (scnt_r != 4'h0) ? scnt_r - 4'h1 : 4'h0;
      cause_nxt = cause_r;
      if (soft_go) begin
         scnt_nxt = prc_pkg::SOFT_RST_CYC;
         cause_nxt[prc_pkg::CAUSE_SW_BIT] = 1'b1;
      end
      chip_nxt = (scnt_nxt != 4'h0);
   end

   // Only the power reset reloads the cause record (external bit set); the soft reset keeps it and adds the software bit.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scnt_r <= 4'h0;
         chip_r <= 1'b0;
         cause_r <= prc_pkg::CAUSE_RST;
      end else begin
         scnt_r <= scnt_nxt;
         chip_r <= chip_nxt;
         cause_r <= cause_nxt;
      end
   end

   prc_pwm_div u_pwm_div (
      .clk_i(clk_i),
      .rst_i(srst),
      .div_code_i(ctrl_r.pwm_div),
      .tick_o(pwm_clk_en_o)
   );

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign unit_clk_en_o = clken_r;
   assign unit_rst_o = urst_r;
   assign unit_ready_o = ready_r;
   assign wake_o = wake_r;
   assign chip_reset_o = chip_r;
   assign irq_o = irq_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst);

   unit_rst_pulse_a: assert property ($rose(|unit_rst_o) |-> (|unit_rst_o)[*4] ##1 !(|unit_rst_o))
      else $error("Unit reset pulse has wrong length");
   rst_one_unit_a: assert property ($rose(|unit_rst_o) |-> (unit_rst_o == $past(wdat[7:0])))
      else $error("Unit reset hit an unrequested unit");
   rst_keeps_clock_a: assert property ((unit_rst_o & ~unit_clk_en_o) == 8'h00)
      else $error("Unit in reset without clock");
   sleep_gated_a: assert property (sleep_i && ctrl_r.gate_en && (rcnt_nxt == 3'h0)
      |=> ((unit_clk_en_o & ~$past(srun_r)) == 8'h00))
      else $error("Clock left running in sleep");
   run_clock_a: assert property ((!sleep_i || !ctrl_r.gate_en) && (rcnt_nxt == 3'h0)
      |=> (unit_clk_en_o == $past(en_r)))
      else $error("Run clock wrong outside gated sleep");
   srun_clock_a: assert property (sleep_i |=> ((unit_clk_en_o & $past(en_r)) == $past(en_r & (srun_r | {8{!ctrl_r.gate_en}})))
      or ($past(rcnt_nxt) != 3'h0))
      else $error("Sleep-run unit lost its clock");
   ready_delay_a: assert property ($rose(unit_ready_o[0]) |-> $past(en_r[0], 5) && !$past(en_r[0], 6)
      or $past(ready_r[0], 1) == 1'b0 && $past(en_r[0], 5))
      else $error("Unit ready before five cycles");
   ready_early_a: assert property ($rose(en_r[0]) |-> (!unit_ready_o[0])[*4])
      else $error("Unit ready too early");
   disabled_idle_a: assert property ((unit_ready_o & ~en_r) == 8'h00)
      else $error("Disabled unit reported ready");
   pll_watch_a: assert property (!ctrl_r.watch_en || !osc_run_i |=> !$rose(ist_r.pll_lost))
      else $error("PLL interrupt while watch idle");
   pll_flag_a: assert property (lost_evt |=> ist_r.pll_lost)
      else $error("PLL loss not flagged");
   pwm_code_a: assert property (ctrl_r.pwm_div <= prc_pkg::PWM_DIV_MAX)
      else $error("PWM ratio code out of range");
   soft_cause_a: assert property (soft_go |=> chip_reset_o && cause_r[prc_pkg::CAUSE_SW_BIT]
      && ((cause_r & $past(cause_r)) == $past(cause_r)))
      else $error("Soft reset lost cause bits");

   unit_rst_c: cover property ($rose(|unit_rst_o));
   sleep_gate_c: cover property (sleep_i && ctrl_r.gate_en ##1 (unit_clk_en_o != en_r));
   pll_lost_c: cover property (lost_evt);
   soft_rst_c: cover property (soft_go);

endmodule
`default_nettype wire

/* sim/prc_far_model.sv */
// Behavioural far side: processor sleep level, unit wake requests, oscillator and PLL ticks.
`timescale 1ns/1ps
`default_nettype none
module prc_far_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sleep_req_i,
   input wire logic [7:0] wake_req_i,
   input wire logic osc_on_i,
   input wire logic pll_on_i,
   output logic sleep_o,
   output logic [7:0] unit_wake_o,
   output logic osc_run_o,
   output logic osc_tick_o,
   output logic pll_tick_o
);
   logic [1:0] div_r;
   // Wake requests pass unfiltered, so the controller must ignore gated units itself.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= 2'h0;
         sleep_o <= 1'b0;
         unit_wake_o <= 8'h00;
         osc_run_o <= 1'b0;
         osc_tick_o <= 1'b0;
         pll_tick_o <= 1'b0;
      end else begin
         div_r <= div_r + 2'h1;
         sleep_o <= sleep_req_i;
         unit_wake_o <= wake_req_i;
         osc_run_o <= osc_on_i;
         osc_tick_o <= osc_on_i && (div_r == 2'h3);
         pll_tick_o <= pll_on_i && div_r[0];
      end
   end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the peripheral reset, sleep and clock controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, sleep_req, osc_on, pll_on;
   logic sleep, osc_run, osc_tick, pll_tick, pwm_en, wake, chip_reset, irq;
   logic [7:0] wb_adr, wake_req, unit_wake, clk_en, unit_rst, ready;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_rd, rd;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   prc_ctrl prc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
      .wb_ack_o(wb_ack), .sleep_i(sleep), .unit_wake_i(unit_wake), .osc_run_i(osc_run),
      .osc_tick_i(osc_tick), .pll_tick_i(pll_tick), .unit_clk_en_o(clk_en), .unit_rst_o(unit_rst),
      .unit_ready_o(ready), .pwm_clk_en_o(pwm_en), .wake_o(wake), .chip_reset_o(chip_reset),
      .irq_o(irq));

   prc_far_model prc_far_model_inst (.clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(sleep_req),
      .wake_req_i(wake_req), .osc_on_i(osc_on), .pll_on_i(pll_on), .sleep_o(sleep),
      .unit_wake_o(unit_wake), .osc_run_o(osc_run), .osc_tick_o(osc_tick), .pll_tick_o(pll_tick));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic results();
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Outputs are sampled in the active region of an edge, so they show the previous edge's update.
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      rd = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      chk(wb_ack, 1'b1);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      wb(1'b0, prc_pkg::OFF_UNIT_EN, 32'h0);
      chk(rd, 32'h0);
      chk(ready, 8'h00);
      chk(clk_en, 8'h00);
      wb(1'b0, prc_pkg::OFF_CAUSE, 32'h0);
      chk(rd, {26'h0, prc_pkg::CAUSE_RST});
      wb(1'b1, 8'h3C, 32'hFFFFFFFF);
      wb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_enable();
      wb(1'b1, prc_pkg::OFF_UNIT_EN, 32'h05);
      repeat (4) @(posedge clk_i);
      chk(ready, 8'h00);
      @(posedge clk_i);
      chk(ready, 8'h05);
      chk(clk_en, 8'h05);
      wb(1'b1, prc_pkg::OFF_UNIT_EN, 32'h04);
      chk(ready, 8'h04);
      @(posedge clk_i);
      chk(clk_en, 8'h04);
      wb(1'b1, prc_pkg::OFF_UNIT_EN, 32'h05);
      repeat (5) @(posedge clk_i);
      chk(ready, 8'h05);
      wb(1'b0, prc_pkg::OFF_UNIT_READY, 32'h0);
      chk(rd, 32'h05);
   endtask

   task automatic t_unit_rst();
      wb(1'b1, prc_pkg::OFF_UNIT_RST, 32'h04);
      for (int i = 0; i < 4; i++) begin
         chk(unit_rst, 8'h04);
         chk(clk_en, 8'h05);
         @(posedge clk_i);
      end
      chk(unit_rst, 8'h00);
      chk(ready, 8'h05);
      wb(1'b0, prc_pkg::OFF_INT_STAT, 32'h0);
      chk(rd, 32'h2);
      chk(irq, 1'b0);
      wb(1'b1, prc_pkg::OFF_INT_MASK, 32'h2);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      wb(1'b1, prc_pkg::OFF_INT_STAT, 32'h2);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
   endtask

   task automatic t_sleep();
      wb(1'b1, prc_pkg::OFF_SLEEP_RUN, 32'h01);
      wb(1'b1, prc_pkg::OFF_CTRL, 32'h0);
      sleep_req <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(clk_en, 8'h05);
      wb(1'b1, prc_pkg::OFF_CTRL, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(clk_en, 8'h01);
      wake_req <= 8'h04;
      repeat (4) @(posedge clk_i);
      chk(wake, 1'b0);
      wake_req <= 8'h01;
      repeat (4) @(posedge clk_i);
      chk(wake, 1'b1);
      wake_req <= 8'h00;
      sleep_req <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(clk_en, 8'h05);
      chk(ready, 8'h05);
      wb(1'b0, prc_pkg::OFF_SLEEP_RUN, 32'h0);
      chk(rd, 32'h01);
   endtask

   task automatic t_pll();
      int n;
      wb(1'b1, prc_pkg::OFF_INT_MASK, 32'h1);
      wb(1'b1, prc_pkg::OFF_CTRL, 32'h3);
      repeat (200) @(posedge clk_i);
      chk(irq, 1'b0);
      pll_on <= 1'b0;
      for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk_i);
      chk(irq, 1'b1);
      wb(1'b1, prc_pkg::OFF_CTRL, 32'h1);
      pll_on <= 1'b1;
      wb(1'b1, prc_pkg::OFF_INT_STAT, 32'h1);
      pll_on <= 1'b0;
      repeat (200) @(posedge clk_i);
      chk(irq, 1'b0);
      osc_on <= 1'b0;
      wb(1'b1, prc_pkg::OFF_CTRL, 32'h3);
      repeat (200) @(posedge clk_i);
      chk(irq, 1'b0);
      wb(1'b1, prc_pkg::OFF_CTRL, 32'h1);
      osc_on <= 1'b1;
      pll_on <= 1'b1;
   endtask

   task automatic t_pwm();
      int cnt;
      for (int code = 0; code < 7; code++) begin
         wb(1'b1, prc_pkg::OFF_CTRL, {27'h0, 3'(code), 2'b01});
         wb(1'b0, prc_pkg::OFF_CTRL, 32'h0);
         chk({29'h0, rd[4:2]}, 32'(code));
         repeat (8) @(posedge clk_i);
         cnt = 0;
         repeat (128) begin
            @(posedge clk_i);
            if (pwm_en === 1'b1) cnt++;
         end
         chk(32'(cnt), 32'(128 >> code));
      end
      wb(1'b1, prc_pkg::OFF_CTRL, {27'h0, 3'h7, 2'b01});
      wb(1'b0, prc_pkg::OFF_CTRL, 32'h0);
      chk({29'h0, rd[4:2]}, {29'h0, prc_pkg::PWM_DIV_MAX});
      wb_sel <= 4'hE;
      wb(1'b1, prc_pkg::OFF_CTRL, {27'h0, 3'h2, 2'b01});
      wb_sel <= 4'hF;
      wb(1'b0, prc_pkg::OFF_CTRL, 32'h0);
      chk({29'h0, rd[4:2]}, {29'h0, prc_pkg::PWM_DIV_MAX});
   endtask

   task automatic t_soft();
      int n;
      wb(1'b1, prc_pkg::OFF_SOFT_RST, 32'h1);
      n = 0;
      while (chip_reset === 1'b1 && n < 20) begin
         n++;
         @(posedge clk_i);
      end
      chk(32'(n), 32'(prc_pkg::SOFT_RST_CYC));
      chk(clk_en, 8'h00);
      chk(ready, 8'h00);
      wb(1'b0, prc_pkg::OFF_UNIT_EN, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, prc_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, prc_pkg::OFF_CAUSE, 32'h0);
      chk(rd, {26'h0, prc_pkg::CAUSE_RST} | (32'h1 << prc_pkg::CAUSE_SW_BIT));
   endtask

   // ****************************************************************
   // Main sequence and timeout
   // ****************************************************************
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end

   initial begin
      rst_i = 1'b1;
      {wb_cyc, wb_stb, wb_we, sleep_req} = 4'h0;
      wb_adr = 8'h00;
      wb_dat = 32'h0;
      wb_sel = 4'hF;
      wake_req = 8'h00;
      osc_on = 1'b1;
      pll_on = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_enable();
      t_unit_rst();
      t_sleep();
      t_pll();
      t_pwm();
      t_soft();
      results();
   end
endmodule
`default_nettype wire
